//--- rtl/fftc_pkg.sv
// Package for the FFT timing and control sequencer: constants, register map, states
//
// Contract
// - Mode bit high selects continuous operation
// - Mode bit low selects one-shot operation
// - Start is held until taken; it launches execution
// - Continuous mode repeats transforms without new start
// - Continuous results carry pair-permuted 10-bit index
// - Done strobe one cycle before last result
// - 5206 cycles start to last result; 1024-cycle window
// - DMA writes bank A, reads bank B together
// - One-shot needs 1024 plus one I/O cycles
// - One-shot reorders results writing them to memory
// - One-shot dual space gives natural result order
// - IO pending pulse four cycles before result strobe
// - Clock enable low freezes all activity (the code keeps toggling half_rate_core_clock in single address space)
// - System reset high stops everything at once
// - Single address space always gives digit-reversed order
// - Single space: half-rate core, alternating memory access
// - Done strobe lasts exactly one clock
// - IO pending pulse lasts exactly one clock
package fftc_pkg;
	// ============================================================
	// Sequence timing, in core clock steps
	localparam logic [12:0] TOTAL_CYCLES = 13'h1456;
	localparam logic [12:0] WINDOW_CYCLES = 13'h0400;
	localparam logic [12:0] RES_FIRST = TOTAL_CYCLES - WINDOW_CYCLES;
	localparam logic [12:0] IO_LEAD = 13'h0004;
	localparam logic [12:0] DMA_CYCLES = 13'h0400;
	// ============================================================
	// Register map, byte addresses
	localparam logic [7:0] CTRL_OFF = 8'h00;
	localparam logic [7:0] CMD_OFF = 8'h04;
	localparam logic [7:0] STATUS_OFF = 8'h08;
	localparam logic [7:0] COUNT_OFF = 8'h0C;
	// CTRL fields
	localparam int CTRL_CONT_BIT = 0;
	localparam int CTRL_CE_BIT = 1;
	localparam logic [1:0] CTRL_RESET = 2'h2;
	// CMD fields, write one to request
	localparam int CMD_START_BIT = 0;
	localparam int CMD_DMA_BIT = 1;
	// STATUS fields
	localparam int STAT_STATE_LSB = 0;
	localparam int STAT_XFER_BIT = 4;
	localparam int STAT_DUAL_BIT = 5;
	localparam int STAT_START_BIT = 6;
	localparam int STAT_DMA_BIT = 7;
	// AXI responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// ============================================================
	// Sequencer states
	typedef enum logic [3:0] {
		FFTC_IDLE = 4'h1,
		FFTC_DMA = 4'h2,
		FFTC_RUN = 4'h4,
		FFTC_FLUSH = 4'h8
	} fftc_state_e;
endpackage

//--- rtl/fftc_top.sv
// FFT timing and control sequencer with AXI4-Lite control registers
`timescale 1ns/1ps
module fftc_top #(
	parameter int DATA_W = 16,
	parameter int IDX_W = 10,
	parameter bit DUAL_SPACE = 1'b1
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic system_reset_in,
	// AXI4-Lite slave
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Host data stream
	input wire logic [DATA_W-1:0] host_data_real,
	input wire logic [DATA_W-1:0] host_data_imag,
	output logic host_xfer_active,
	output logic io_pending,
	// Results
	output logic result_strobe,
	output logic [DATA_W-1:0] result_real_bus,
	output logic [DATA_W-1:0] result_imag_bus,
	output logic [IDX_W-1:0] result_index,
	output logic done,
	// Memory bank A
	output logic [IDX_W-1:0] ram_a_addr,
	output logic [2*DATA_W-1:0] ram_a_wdata,
	input wire logic [2*DATA_W-1:0] ram_a_rdata,
	output logic ram_a_cs_n,
	output logic ram_a_oe_n,
	output logic ram_a_we_n,
	// Memory bank B
	output logic [IDX_W-1:0] ram_b_addr,
	output logic [2*DATA_W-1:0] ram_b_wdata,
	input wire logic [2*DATA_W-1:0] ram_b_rdata,
	output logic ram_b_cs_n,
	output logic ram_b_oe_n,
	output logic ram_b_we_n,
	// Single address space core clock
	output logic half_rate_core_clock
);
	import fftc_pkg::*;

	// ============================================================
	// AXI4-Lite slave
	logic aw_held, w_held;
	logic [7:0] aw_addr_q;
	logic [31:0] w_data_q;
	logic [3:0] w_strb_q;
	logic wr_fire;
	logic [1:0] ctrl;
	logic start_pend, dma_pend;
	logic [15:0] xform_count;
	fftc_state_e state;
	logic [12:0] cnt;
	logic half_phase;
	logic step;

	assign wr_fire = aw_held && w_held && !s_axi_bvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			aw_addr_q <= 8'h00;
			s_axi_awready <= 1'b0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_held <= 1'b1;
			aw_addr_q <= s_axi_awaddr;
			s_axi_awready <= 1'b0;
		end else begin
			if (wr_fire) begin
				aw_held <= 1'b0;
			end
			s_axi_awready <= !aw_held && !s_axi_bvalid;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held <= 1'b0;
			w_data_q <= 32'h00000000;
			w_strb_q <= 4'h0;
			s_axi_wready <= 1'b0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_held <= 1'b1;
			w_data_q <= s_axi_wdata;
			w_strb_q <= s_axi_wstrb;
			s_axi_wready <= 1'b0;
		end else begin
			if (wr_fire) begin
				w_held <= 1'b0;
			end
			s_axi_wready <= !w_held && !s_axi_bvalid;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= (aw_addr_q[7:2] == CTRL_OFF[7:2] || aw_addr_q[7:2] == CMD_OFF[7:2])
				? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Control bits; the mode is sampled by the sequencer at each transform end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl <= CTRL_RESET;
		end else if (wr_fire && aw_addr_q[7:2] == CTRL_OFF[7:2] && w_strb_q[0]) begin
			ctrl <= w_data_q[1:0];
		end
	end

	// Commands stay pending until the sequencer steps in idle, so a stalled core loses none
	always_ff @(posedge aclk) begin
		if (!aresetn || system_reset_in) begin
			start_pend <= 1'b0;
			dma_pend <= 1'b0;
		end else if (wr_fire && aw_addr_q[7:2] == CMD_OFF[7:2] && w_strb_q[0]) begin
			start_pend <= w_data_q[CMD_START_BIT] | (start_pend & ~(step & state == FFTC_IDLE));
			dma_pend <= w_data_q[CMD_DMA_BIT] | (dma_pend & ~(step & state == FFTC_IDLE));
		end else if (step && state == FFTC_IDLE) begin
			start_pend <= 1'b0;
			dma_pend <= dma_pend & start_pend;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= RESP_OKAY;
			unique case (s_axi_araddr[7:2])
				CTRL_OFF[7:2]: s_axi_rdata <= {30'h00000000, ctrl};
				CMD_OFF[7:2]: s_axi_rdata <= 32'h00000000;
				STATUS_OFF[7:2]: s_axi_rdata <= {24'h000000, dma_pend, start_pend,
					DUAL_SPACE, host_xfer_active, state};
				COUNT_OFF[7:2]: s_axi_rdata <= {16'h0000, xform_count};
				default: begin
					s_axi_rdata <= 32'h00000000;
					s_axi_rresp <= RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rvalid) begin
			if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end else begin
			s_axi_arready <= 1'b1;
		end
	end

	// ============================================================
	// Core step enable
	logic cont, dig_order;
	assign cont = ctrl[CTRL_CONT_BIT];
	// Digit order whenever continuous or single address space
	assign dig_order = cont || !DUAL_SPACE;

	// Divider makes the half-rate core clock; in single address space the core runs on its enable
	always_ff @(posedge aclk) begin
		if (!aresetn || system_reset_in) begin
			half_phase <= 1'b0;
		end else begin
			half_phase <= !half_phase;
		end
	end
	assign step = ctrl[CTRL_CE_BIT] && (DUAL_SPACE || half_phase);

	// ============================================================
	// Sequencer
	always_ff @(posedge aclk) begin
		if (!aresetn || system_reset_in) begin
			state <= FFTC_IDLE;
			cnt <= 13'h0000;
		end else if (step) begin
			unique case (state)
				FFTC_IDLE: begin
					cnt <= 13'h0000;
					if (start_pend) begin
						state <= FFTC_RUN;
					end else if (dma_pend) begin
						state <= FFTC_DMA;
					end
				end
				FFTC_DMA: begin
					cnt <= cnt + 13'h0001;
					if (cnt == DMA_CYCLES - 13'h0001) begin
						state <= FFTC_IDLE;
					end
				end
				FFTC_RUN: begin
					if (cnt == TOTAL_CYCLES - 13'h0001) begin
						cnt <= 13'h0000;
						// Continuous runs on; one-shot adds a final write cycle
						state <= cont ? FFTC_RUN : FFTC_FLUSH;
					end else begin
						cnt <= cnt + 13'h0001;
					end
				end
				FFTC_FLUSH: begin
					state <= FFTC_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn || system_reset_in) begin
			xform_count <= 16'h0000;
		end else if (step && state == FFTC_RUN && cnt == TOTAL_CYCLES - 13'h0001) begin
			xform_count <= xform_count + 16'h0001;
		end
	end

	// ============================================================
	// Result index generation
	logic in_window;
	logic [IDX_W-1:0] seq, perm;
	assign in_window = state == FFTC_RUN && cnt >= RES_FIRST;
	assign seq = IDX_W'(cnt - RES_FIRST);
	genvar gi;
	generate
		for (gi = 0; gi < IDX_W / 2; gi++) begin : g_perm
			// Index order a1,a0,a3,a2,...,a9,a8
			assign perm[IDX_W-1-2*gi] = seq[2*gi+1];
			assign perm[IDX_W-2-2*gi] = seq[2*gi];
		end
	endgenerate

	// Result and handshake outputs; pulses are gated by the step enable
	always_ff @(posedge aclk) begin
		if (!aresetn || system_reset_in) begin
			result_strobe <= 1'b0;
			result_real_bus <= '0;
			result_imag_bus <= '0;
			result_index <= '0;
			done <= 1'b0;
			io_pending <= 1'b0;
			host_xfer_active <= 1'b0;
		end else begin
			done <= step && state == FFTC_RUN && cnt == TOTAL_CYCLES - 13'h0002;
			io_pending <= step && state == FFTC_RUN && cnt == RES_FIRST - IO_LEAD;
			if (step) begin
				result_strobe <= in_window;
				host_xfer_active <= state == FFTC_DMA || (in_window && cont);
				if (in_window) begin
					result_index <= dig_order ? perm : seq;
					result_real_bus <= DUAL_SPACE ? ram_b_rdata[2*DATA_W-1:DATA_W]
						: ram_a_rdata[2*DATA_W-1:DATA_W];
					result_imag_bus <= DUAL_SPACE ? ram_b_rdata[DATA_W-1:0]
						: ram_a_rdata[DATA_W-1:0];
				end
			end
		end
	end

	// ============================================================
	// Memory control
	// The butterfly datapath sits outside; ranks here only sweep addresses
	logic active;
	assign active = state != FFTC_IDLE;
	always_ff @(posedge aclk) begin
		if (!aresetn || system_reset_in) begin
			ram_a_addr <= '0;
			ram_a_wdata <= '0;
			ram_a_cs_n <= 1'b1;
			ram_a_oe_n <= 1'b1;
			ram_a_we_n <= 1'b1;
			ram_b_addr <= '0;
			ram_b_wdata <= '0;
			ram_b_cs_n <= 1'b1;
			ram_b_oe_n <= 1'b1;
			ram_b_we_n <= 1'b1;
		end else if (!ctrl[CTRL_CE_BIT]) begin
			ram_a_cs_n <= 1'b1;
			ram_a_oe_n <= 1'b1;
			ram_a_we_n <= 1'b1;
			ram_b_cs_n <= 1'b1;
			ram_b_oe_n <= 1'b1;
			ram_b_we_n <= 1'b1;
		end else if (!DUAL_SPACE) begin
			// One shared port: read on one edge, write on the next
			ram_a_cs_n <= !active;
			ram_a_oe_n <= !(active && !half_phase);
			ram_a_we_n <= !(active && half_phase);
			ram_a_addr <= state == FFTC_DMA ? IDX_W'(cnt) : (in_window ? seq : IDX_W'(cnt));
			ram_a_wdata <= state == FFTC_DMA || (in_window && cont)
				? {host_data_real, host_data_imag} : ram_a_rdata;
			ram_b_cs_n <= 1'b1;
			ram_b_oe_n <= 1'b1;
			ram_b_we_n <= 1'b1;
		end else if (state == FFTC_DMA) begin
			// Load new input into A while previous results come out of B
			ram_a_cs_n <= 1'b0;
			ram_a_oe_n <= 1'b1;
			ram_a_we_n <= 1'b0;
			ram_a_addr <= IDX_W'(cnt);
			ram_a_wdata <= {host_data_real, host_data_imag};
			ram_b_cs_n <= 1'b0;
			ram_b_oe_n <= 1'b0;
			ram_b_we_n <= 1'b1;
			ram_b_addr <= IDX_W'(cnt);
		end else if (in_window) begin
			ram_b_cs_n <= 1'b0;
			ram_a_cs_n <= 1'b0;
			if (cont) begin
				ram_a_oe_n <= 1'b1;
				ram_a_we_n <= 1'b0;
				ram_a_addr <= seq;
				ram_a_wdata <= {host_data_real, host_data_imag};
				ram_b_oe_n <= 1'b0;
				ram_b_we_n <= 1'b1;
				ram_b_addr <= seq;
			end else begin
				// Reorder while writing: read digit order, write natural address
				ram_a_oe_n <= 1'b0;
				ram_a_we_n <= 1'b1;
				ram_a_addr <= perm;
				ram_b_oe_n <= 1'b1;
				ram_b_we_n <= 1'b0;
				ram_b_addr <= seq;
				ram_b_wdata <= ram_a_rdata;
			end
		end else begin
			// Both banks serve every rank; the flush cycle ends the last write
			ram_a_cs_n <= !active;
			ram_a_oe_n <= !(state == FFTC_RUN);
			ram_a_we_n <= 1'b1;
			ram_a_addr <= IDX_W'(cnt);
			ram_b_cs_n <= !active;
			ram_b_oe_n <= 1'b1;
			ram_b_we_n <= !active;
			ram_b_addr <= IDX_W'(cnt);
			ram_b_wdata <= ram_a_rdata;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			half_rate_core_clock <= 1'b0;
		end else begin
			half_rate_core_clock <= DUAL_SPACE ? 1'b0 : !half_phase;
		end
	end

	// ============================================================
	// Assertions
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn || system_reset_in);

	done_one_cycle_a: assert property (done |=> !done)
		else $error("done strobe longer than one clock");
	io_one_cycle_a: assert property (io_pending |=> !io_pending)
		else $error("io pending longer than one clock");
	io_lead_four_a: assert property (DUAL_SPACE && io_pending && ctrl[CTRL_CE_BIT]
		##1 ctrl[CTRL_CE_BIT] [*3] |=> $rose(result_strobe))
		else $error("result strobe not four clocks after io pending");
	done_before_last_a: assert property (done && step |=> result_strobe
		&& result_index == (dig_order ? {2'h3, 8'hFF} : {IDX_W{1'b1}}))
		else $error("done not one clock before last result");
	window_start_a: assert property ($rose(result_strobe) |-> cnt == RES_FIRST + 13'h0001
		&& result_index == '0)
		else $error("result window starts at wrong count");
	perm_index_a: assert property ($rose(result_strobe) && cont && step
		|=> result_index == 10'h100)
		else $error("second continuous index not permuted");
	cont_repeat_a: assert property (state == FFTC_RUN && cnt == TOTAL_CYCLES - 13'h0001
		&& step && cont |=> state == FFTC_RUN && cnt == 13'h0000)
		else $error("continuous mode did not restart");
	oneshot_stop_a: assert property (state == FFTC_RUN && cnt == TOTAL_CYCLES - 13'h0001
		&& step && !cont |=> state == FFTC_FLUSH ##1 (!step || state == FFTC_IDLE))
		else $error("one-shot did not stop after flush");
	dma_banks_a: assert property (DUAL_SPACE && state == FFTC_DMA && ctrl[CTRL_CE_BIT]
		|=> !ram_a_we_n && !ram_b_oe_n && host_xfer_active)
		else $error("dma not writing A and reading B");
	freeze_a: assert property (!ctrl[CTRL_CE_BIT] |=> $stable(cnt) && ram_a_cs_n
		&& ram_b_cs_n && $stable(result_strobe))
		else $error("activity while clock enable low");
	sys_reset_a: assert property (@(posedge aclk) disable iff (!aresetn)
		system_reset_in |=> state == FFTC_IDLE && ram_a_cs_n && ram_b_cs_n && !done)
		else $error("system reset did not stop activity");
	half_clock_a: assert property (!DUAL_SPACE |=> half_rate_core_clock
		!= $past(half_rate_core_clock))
		else $error("half-rate clock not toggling");

	cont_done_c: cover property (cont && done ##[1:4] state == FFTC_RUN);
	dma_done_c: cover property (state == FFTC_DMA ##1 state == FFTC_IDLE);
	freeze_window_c: cover property (result_strobe && !ctrl[CTRL_CE_BIT]);
	oneshot_flush_c: cover property (state == FFTC_FLUSH && !cont);
endmodule

//--- tb/fftc_far_model.sv
// Behavioural host data source and the two RAM banks facing the sequencer
`timescale 1ns/1ps
module fftc_far_model (
	// Clock
	input wire logic aclk,
	// Host stream
	input wire logic host_xfer_active,
	output logic [15:0] host_data_real,
	output logic [15:0] host_data_imag,
	// Memory bank A
	input wire logic [9:0] ram_a_addr,
	input wire logic [31:0] ram_a_wdata,
	output logic [31:0] ram_a_rdata,
	input wire logic ram_a_cs_n,
	input wire logic ram_a_oe_n,
	input wire logic ram_a_we_n,
	// Memory bank B
	input wire logic [9:0] ram_b_addr,
	input wire logic [31:0] ram_b_wdata,
	output logic [31:0] ram_b_rdata,
	input wire logic ram_b_cs_n,
	input wire logic ram_b_oe_n,
	input wire logic ram_b_we_n
);
	logic [31:0] mem_a [1024];
	logic [31:0] mem_b [1024];
	initial begin
		for (int i = 0; i < 1024; i++) begin
			mem_a[i] = {16'h0000, i[15:0]};
			mem_b[i] = ~mem_a[i];
		end
		host_data_real = 16'h0000;
		host_data_imag = 16'h0000;
		ram_a_rdata = 32'h00000000;
		ram_b_rdata = 32'h00000000;
	end
	// ============================================================
	// Host: fresh sample each clock while host_xfer_active is high (DMA or continuous window), scrambled otherwise
	// This host reads and writes at once, so one DMA pass serves both
	always @(posedge aclk) begin
		host_data_real <= host_xfer_active ? 16'($urandom) : ~host_data_real;
		host_data_imag <= host_xfer_active ? 16'($urandom) : ~host_data_imag;
	end
	// ============================================================
	// Banks: a deselected bus shows a changing pattern, never stale data
	always @(posedge aclk) begin
		if (!ram_a_cs_n && !ram_a_we_n) begin
			mem_a[ram_a_addr] <= ram_a_wdata;
		end
		if (!ram_b_cs_n && !ram_b_we_n) begin
			mem_b[ram_b_addr] <= ram_b_wdata;
		end
		ram_a_rdata <= (!ram_a_cs_n && !ram_a_oe_n) ? mem_a[ram_a_addr] : ~ram_a_rdata;
		ram_b_rdata <= (!ram_b_cs_n && !ram_b_oe_n) ? mem_b[ram_b_addr] : ~ram_b_rdata;
	end
endmodule

//--- tb/fftc_top_test.sv
// Self-checking bench for the FFT sequencer: registers, DMA, both modes, freeze, reset
`timescale 1ns/1ps
module fftc_top_test;
	import fftc_pkg::*;
	logic aclk = 1'b0, aresetn = 1'b0, system_reset_in = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h00000000;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic [15:0] hd_r, hd_i, res_r, res_i;
	logic xfer, io_pending, result_strobe, done, half_clk;
	logic [9:0] result_index, a_addr, b_addr;
	logic [31:0] a_wd, a_rd, b_wd, b_rd;
	logic a_cs_n, a_oe_n, a_we_n, b_cs_n, b_oe_n, b_we_n;
	int err_total = 0, cmp_count = 0, cyc = 0;
	int since_io = 99, io_cnt = 0, win = 0, done_n = 0, last_done = 0, last_gap = 0;
	int xfer_n = 0, xfer_last = 0;
	logic strobe_d = 1'b0, done_d = 1'b0, io_d = 1'b0, xfer_d = 1'b0;
	logic [31:0] hd_d = 32'h00000000;
	logic [9:0] idx_q [$];
	always #25 aclk = ~aclk;
	// Dual address space, tied as a constant
	fftc_top #(.DUAL_SPACE(1'b1)) u_fftc_top (.aclk(aclk), .aresetn(aresetn),
		.system_reset_in(system_reset_in),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.host_data_real(hd_r), .host_data_imag(hd_i), .host_xfer_active(xfer),
		.io_pending(io_pending), .result_strobe(result_strobe), .result_real_bus(res_r),
		.result_imag_bus(res_i), .result_index(result_index), .done(done),
		.ram_a_addr(a_addr), .ram_a_wdata(a_wd), .ram_a_rdata(a_rd), .ram_a_cs_n(a_cs_n),
		.ram_a_oe_n(a_oe_n), .ram_a_we_n(a_we_n), .ram_b_addr(b_addr), .ram_b_wdata(b_wd),
		.ram_b_rdata(b_rd), .ram_b_cs_n(b_cs_n), .ram_b_oe_n(b_oe_n), .ram_b_we_n(b_we_n),
		.half_rate_core_clock(half_clk));
	fftc_far_model u_fftc_far_model (.aclk(aclk), .host_xfer_active(xfer),
		.host_data_real(hd_r), .host_data_imag(hd_i), .ram_a_addr(a_addr), .ram_a_wdata(a_wd),
		.ram_a_rdata(a_rd), .ram_a_cs_n(a_cs_n), .ram_a_oe_n(a_oe_n), .ram_a_we_n(a_we_n),
		.ram_b_addr(b_addr), .ram_b_wdata(b_wd), .ram_b_rdata(b_rd), .ram_b_cs_n(b_cs_n),
		.ram_b_oe_n(b_oe_n), .ram_b_we_n(b_we_n));
	// ============================================================
	// Checking and reporting
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic complete_run();
		$display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// Whole plan needs about 34000 cycles
	always @(posedge aclk) begin
		cyc++;
		if (cyc > 40000) begin
			err_total++;
			complete_run();
		end
	end
	// ============================================================
	// Monitor: pulls the oldest expected index whenever a result shows
	always @(posedge aclk) begin
		since_io = io_pending ? 0 : since_io + 1;
		if (result_strobe) begin
			win++;
			if (idx_q.size() > 0) begin
				cmp({22'h0, result_index}, {22'h0, idx_q.pop_front()});
			end else begin
				cmp({31'h0, result_strobe}, 32'h00000000);
			end
			if (!strobe_d) cmp(since_io, 32'(IO_LEAD));
		end
		if (strobe_d && !result_strobe) begin
			cmp(win, 32'(WINDOW_CYCLES));
			win = 0;
		end
		if (done) begin
			cmp(win, 32'(WINDOW_CYCLES) - 1);
			cmp({31'h0, done_d}, 32'h00000000);
			done_n++;
			last_gap = cyc - last_done;
			last_done = cyc;
		end
		if (io_pending) begin
			io_cnt++;
			cmp({31'h0, io_d}, 32'h00000000);
		end
		if (xfer) xfer_n++;
		else if (xfer_d) begin
			xfer_last = xfer_n;
			xfer_n = 0;
		end
		// Host samples land in bank A while bank B is read back
		if (xfer && !a_cs_n) begin
			cmp(a_wd, hd_d);
			cmp({30'h0, a_we_n, b_oe_n}, 32'h00000000);
		end
		strobe_d = result_strobe;
		hd_d = {hd_r, hd_i};
		done_d = done;
		io_d = io_pending;
		xfer_d = xfer;
	end
	// ============================================================
	// AXI4-Lite master
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		bready <= 1'b0;
		cmp({30'h0, bresp}, {30'h0, er});
		@(posedge aclk);
	endtask
	task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		rready <= 1'b0;
		cmp(rdata, ed);
		cmp({30'h0, rresp}, {30'h0, er});
		@(posedge aclk);
	endtask
	function automatic logic [9:0] perm(input logic [9:0] n);
		return {n[1:0], n[3:2], n[5:4], n[7:6], n[9:8]};
	endfunction
	// ============================================================
	// Main sequence
	initial begin
		void'($urandom(32'hf97f));
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		axi_rd(CTRL_OFF, {30'h0, CTRL_RESET}, RESP_OKAY);
		axi_rd(STATUS_OFF, 32'h00000021, RESP_OKAY);
		axi_rd(8'h10, 32'h00000000, RESP_SLVERR);
		axi_wr(STATUS_OFF, 32'h0000000F, RESP_SLVERR);
		$display("Test registers finished");
		axi_wr(CMD_OFF, 32'h00000002, RESP_OKAY);
		wait (xfer_last != 0);
		cmp(xfer_last, 32'(DMA_CYCLES));
		$display("Test DMA finished");
		// Start held pending while frozen, then the single run completes
		axi_wr(CTRL_OFF, 32'h00000000, RESP_OKAY);
		for (int i = 0; i < 1024; i++) idx_q.push_back(10'(i));
		axi_wr(CMD_OFF, 32'h00000001, RESP_OKAY);
		repeat (5400) @(posedge aclk);
		cmp(io_cnt, 0);
		// Random upper bits must be ignored by the control register
		axi_wr(CTRL_OFF, {30'($urandom()), 2'h2}, RESP_OKAY);
		axi_rd(CTRL_OFF, 32'h00000002, RESP_OKAY);
		wait (done_n == 1);
		repeat (5300) @(posedge aclk);
		cmp(io_cnt, 1);
		cmp(idx_q.size(), 0);
		// Final write is long done, so a read-back DMA may begin
		xfer_last = 0;
		axi_wr(CMD_OFF, 32'h00000002, RESP_OKAY);
		wait (xfer_last != 0);
		cmp(xfer_last, 32'(DMA_CYCLES));
		$display("Test one-shot finished");
		// Two back-to-back transforms from one start
		axi_wr(CTRL_OFF, 32'h00000003, RESP_OKAY);
		for (int i = 0; i < 2048; i++) idx_q.push_back(perm(10'(i)));
		axi_wr(CMD_OFF, 32'h00000001, RESP_OKAY);
		wait (done_n == 3);
		cmp(last_gap, 32'(TOTAL_CYCLES));
		repeat (200) @(posedge aclk);
		system_reset_in <= 1'b1;
		repeat (2) @(posedge aclk);
		system_reset_in <= 1'b0;
		repeat (5400) @(posedge aclk);
		cmp(io_cnt, 3);
		cmp({31'h0, a_cs_n & b_cs_n}, 32'h00000001);
		cmp({res_r, res_i}, 32'h00000000);
		cmp({31'h0, half_clk}, 32'h00000000);
		axi_rd(STATUS_OFF, 32'h00000021, RESP_OKAY);
		cmp(idx_q.size(), 0);
		$display("Test continuous and reset finished");
		complete_run();
	end
endmodule
